// ### rtl/sar_regs.svh
// Register offsets, field positions, reset values and counts of the ADC control
`ifndef SAR_REGS_SVH
`define SAR_REGS_SVH

`define REG_CTRL        3'h0
`define REG_CFG         3'h1
`define REG_ACC         3'h2
`define REG_RES_HIGH    3'h3
`define REG_RES_LOW     3'h4

`define CTRL_MODE_LSB   0
`define CTRL_LPTRACK    3
`define CTRL_BUSY       4
`define CTRL_DONE       5
`define CFG_DIV_LSB     0
`define CFG_BURST       5
`define ACC_RPT_LSB     0
`define ACC_JST_LSB     3

`define CTRL_RESET      8'h00
`define CFG_RESET       8'h00
`define ACC_RESET       8'h00

`define MODE_SW         3'h0
`define MODE_TIMER0     3'h1
`define MODE_TIMER2     3'h2
`define MODE_TIMER3     3'h3
`define MODE_EXT        3'h4

`define JST_LEFT        3'h4
`define LP_TRACK_TICKS  3'h3
`define POWERUP_TICKS   3'h4

`endif

// ### rtl/sar_pkg.sv
// Types shared by the ADC control modules
package sar_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_POWER,
        ST_TRACK,
        ST_START,
        ST_WAIT
    } state_e;
endpackage

// ### rtl/acc_if.sv
// Link between the sequencer and the accumulator
`timescale 1ns/1ns
`default_nettype none
interface acc_if;
    logic        clear;
    logic        add;
    logic        last;
    logic [9:0]  code;
    logic [2:0]  justify;
    logic [15:0] result;
    modport ctl (output clear, add, last, code, justify, input result);
    modport acc (input clear, add, last, code, justify, output result);
endinterface
`default_nettype wire

// ### rtl/sar_clock_div.sv
// Converter clock enable divider
`timescale 1ns/1ns
`default_nettype none
module sar_clock_div (
    input  wire logic       clk,     // system clock
    input  wire logic       rst,     // sync reset
    input  wire logic       run,     // divider active
    input  wire logic       burst,   // use low-power oscillator ticks
    input  wire logic       lpo_tick,// low-power oscillator pulse
    input  wire logic [4:0] divide,  // divide field
    output logic            tick     // converter clock enable
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic       next_tick;
    logic       src;

    always_comb
    begin
        src        = burst ? lpo_tick : 1'b1;
        next_count = count;
        next_tick  = 1'b0;
        if (!run)
        begin
            next_count = 5'h00;
        end
        else if (src)
        begin
            if (count == divide)
            begin
                next_count = 5'h00;
                next_tick  = 1'b1;
            end
            else
            begin
                next_count = count + 5'h01;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count <= 5'h00;
            tick  <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule
`default_nettype wire

// ### rtl/sar_accum.sv
// Sample accumulator and result formatter
`timescale 1ns/1ns
`default_nettype none
`include "sar_regs.svh"
module sar_accum (
    input  wire logic clk,  // system clock
    input  wire logic rst,  // sync reset
    acc_if.acc        bus   // sequencer side
);
    logic [15:0] sum;
    logic [15:0] next_sum;
    logic [15:0] result;
    logic [15:0] next_result;
    logic [15:0] total;

    assign bus.result = result;

    always_comb
    begin
        // RL3 RL4 zero-extended code
        total       = sum + {6'h00, bus.code};
        next_sum    = sum;
        next_result = result;
        if (bus.clear)
        begin
            next_sum = 16'h0000;
        end
        if (bus.add)
        begin
            next_sum = total;
            if (bus.last)
            begin
                next_sum = 16'h0000;
                // RL2 RL20 left placement
                if (bus.justify == `JST_LEFT)
                begin
                    next_result = {total[9:0], 6'h00};
                end
                else
                begin
                    // RL8 shift right
                    next_result = total >> bus.justify[1:0];
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sum    <= 16'h0000;
            result <= 16'h0000;
        end
        else
        begin
            sum    <= next_sum;
            result <= next_result;
        end
    end
endmodule
`default_nettype wire

// ### rtl/sar_control.sv
// Conversion start, sequencing, accumulation and result registers of the ADC
//
// Notes on behaviour
// RL1 - Each finished conversion or series lands in a high/low result byte pair.
// RL2 - Justify field 000 gives right-justified, 100 left-justified output.
// RL3 - Single samples are 10-bit codes; full scale 0x03FF or 0xFFC0.
// RL4 - Result bits not holding the code read as zero.
// RL5 - With repeat above one, result is the sum, updated after the last.
// RL6 - Repeat field sums 4, 8, 16, 32 or 64 samples, or one.
// RL7 - Software keeps right justification whenever repeat exceeds one.
// RL8 - Sum kept in 16 bits; may be shifted right by 1, 2 or 3.
// RL9 - Converter clock is system clock or low-power oscillator, divided.
// RL10 - Start mode picks software, timer 0, 2, 3 or external edge.
// RL11 - Writing one to busy starts; busy stays one until completion.
// RL12 - Falling busy sets the done flag; results valid while it is set. The code sets done only when busy falls after the last sample of a series.
// RL13 - Software polls the done flag rather than the busy bit.
// RL14 - Timer 2/3 trigger uses low overflow in 8-bit, high in 16-bit.
// RL15 - Software reserves the shared external start pin in the port matrix.
// RL16 - Burst mode powers up, samples, accumulates and shuts down alone.
// RL17 - Burst: one start runs the series; otherwise one start per sample.
// RL18 - In burst mode starts come at most once every four clocks.
// RL19 - Low-power tracking adds 3 converter clocks; external start tracks low.
// RL20 - Left-justified code occupies the upper ten bits of the pair.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "sar_regs.svh"
module sar_control (
    input  wire logic       clk,              // system clock, 50 MHz
    input  wire logic       rst,              // sync reset, active high
    input  wire logic [2:0] addr,             // register address
    input  wire logic [7:0] wdata,            // write data
    input  wire logic       wr,               // write strobe
    input  wire logic       rd,               // read strobe
    output logic      [7:0] rdata,            // read data, cycle after rd
    input  wire logic       timer0_ovf,       // timer 0 overflow pulse
    input  wire logic       timer2_low_ovf,   // timer 2 low byte overflow
    input  wire logic       timer2_high_ovf,  // timer 2 high byte overflow
    input  wire logic       timer2_split,     // timer 2 in 8-bit mode
    input  wire logic       timer3_low_ovf,   // timer 3 low byte overflow
    input  wire logic       timer3_high_ovf,  // timer 3 high byte overflow
    input  wire logic       timer3_split,     // timer 3 in 8-bit mode
    input  wire logic       external_convert_start, // external start input
    input  wire logic       lpo_tick,         // low-power oscillator pulse
    output logic            converter_power,  // converter powered
    output logic            tracking,         // track phase active
    output logic            sample_start,     // begin one conversion
    input  wire logic       sample_done,      // conversion finished pulse
    input  wire logic [9:0] sample_code,      // converted code
    output logic            conversion_busy_bit, // busy status
    output logic            conversion_done_flag // completion flag
);
    logic [7:0] converter_control_reg;
    logic [7:0] converter_config_reg;
    logic [7:0] accumulator_config_reg;
    logic [7:0] next_ctrl;
    logic [7:0] next_cfg;
    logic [7:0] next_acc;
    logic [7:0] next_rdata;

    sar_pkg::state_e state;
    sar_pkg::state_e next_state;
    logic [2:0] cnt;
    logic [2:0] next_cnt;
    logic [6:0] seq;
    logic [6:0] next_seq;
    logic       busy;
    logic       next_busy;
    logic       done;
    logic       next_done;
    logic       powered;
    logic       next_powered;
    logic       ext_prev;
    logic       next_start;
    logic       trig;
    logic       sar_tick;

    logic [2:0] start_mode_field;
    logic       low_power_track_bit;
    logic [4:0] clock_divide_field;
    logic       burst_enable;
    logic [2:0] repeat_count_field;
    logic [2:0] justify_shift_field;
    logic [6:0] repeat_len;
    logic       ext_mode;
    logic       ctrl_wr;

    acc_if acc ();

    assign start_mode_field    = converter_control_reg[`CTRL_MODE_LSB +: 3];
    assign low_power_track_bit = converter_control_reg[`CTRL_LPTRACK];
    assign clock_divide_field  = converter_config_reg[`CFG_DIV_LSB +: 5];
    assign burst_enable        = converter_config_reg[`CFG_BURST];
    assign repeat_count_field  = accumulator_config_reg[`ACC_RPT_LSB +: 3];
    assign justify_shift_field = accumulator_config_reg[`ACC_JST_LSB +: 3];
    assign ext_mode            = (start_mode_field == `MODE_EXT);
    assign ctrl_wr             = wr && (addr == `REG_CTRL);

    assign conversion_busy_bit  = busy;
    assign conversion_done_flag = done;
    // RL16 shut down between bursts
    assign converter_power = !burst_enable || powered;
    assign tracking        = (state == sar_pkg::ST_TRACK);

    // RL6 series length
    always_comb
    begin
        unique case (repeat_count_field)
            3'h0:    repeat_len = 7'h01;
            3'h1:    repeat_len = 7'h04;
            3'h2:    repeat_len = 7'h08;
            3'h3:    repeat_len = 7'h10;
            3'h4:    repeat_len = 7'h20;
            default: repeat_len = 7'h40;
        endcase
    end

    // RL10 trigger select
    always_comb
    begin
        unique case (start_mode_field)
            // RL11 software start
            `MODE_SW:     trig = ctrl_wr && wdata[`CTRL_BUSY];
            `MODE_TIMER0: trig = timer0_ovf;
            // RL14 timer byte choice
            `MODE_TIMER2: trig = timer2_split ? timer2_low_ovf
                                              : timer2_high_ovf;
            `MODE_TIMER3: trig = timer3_split ? timer3_low_ovf
                                              : timer3_high_ovf;
            `MODE_EXT:    trig = external_convert_start && !ext_prev;
            default:      trig = 1'b0;
        endcase
    end

    // RL9 converter clock
    sar_clock_div u_div (
        .clk      (clk),
        .rst      (rst),
        .run      (state != sar_pkg::ST_IDLE),
        .burst    (burst_enable),
        .lpo_tick (lpo_tick),
        .divide   (clock_divide_field),
        .tick     (sar_tick)
    );

    sar_accum u_acc (
        .clk (clk),
        .rst (rst),
        .bus (acc.acc)
    );

    assign acc.code    = sample_code;
    assign acc.justify = justify_shift_field;

    // Register file and read port
    always_comb
    begin
        next_ctrl  = converter_control_reg;
        next_cfg   = converter_config_reg;
        next_acc   = accumulator_config_reg;
        next_rdata = 8'h00;
        if (wr)
        begin
            unique case (addr)
                `REG_CTRL: next_ctrl = {4'h0, wdata[3:0]};
                `REG_CFG:  next_cfg  = {2'h0, wdata[5:0]};
                `REG_ACC:  next_acc  = {2'h0, wdata[5:0]};
                default:   next_ctrl = converter_control_reg;
            endcase
        end
        if (rd)
        begin
            unique case (addr)
                `REG_CTRL:     next_rdata = {2'h0, done, busy,
                                             converter_control_reg[3:0]};
                `REG_CFG:      next_rdata = converter_config_reg;
                `REG_ACC:      next_rdata = accumulator_config_reg;
                // RL1 byte pair
                `REG_RES_HIGH: next_rdata = acc.result[15:8];
                `REG_RES_LOW:  next_rdata = acc.result[7:0];
                default:       next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            converter_control_reg  <= `CTRL_RESET;
            converter_config_reg   <= `CFG_RESET;
            accumulator_config_reg <= `ACC_RESET;
            rdata                  <= 8'h00;
        end
        else
        begin
            converter_control_reg  <= next_ctrl;
            converter_config_reg   <= next_cfg;
            accumulator_config_reg <= next_acc;
            rdata                  <= next_rdata;
        end
    end

    // Conversion sequencer
    always_comb
    begin
        next_state   = state;
        next_cnt     = cnt;
        next_seq     = seq;
        next_busy    = busy;
        next_done    = done;
        next_powered = powered;
        next_start   = 1'b0;
        acc.clear    = 1'b0;
        acc.add      = 1'b0;
        acc.last     = 1'b0;
        if (ctrl_wr && !wdata[`CTRL_DONE])
        begin
            next_done = 1'b0;
        end
        unique case (state)
            sar_pkg::ST_IDLE:
            begin
                if (trig)
                begin
                    next_busy = 1'b1;
                    next_cnt  = 3'h0;
                    acc.clear = (seq == 7'h00);
                    // RL16 power up first
                    if (burst_enable && !powered)
                    begin
                        next_state = sar_pkg::ST_POWER;
                    end
                    // RL19 extra tracking
                    else if (low_power_track_bit && !ext_mode)
                    begin
                        next_state = sar_pkg::ST_TRACK;
                    end
                    else
                    begin
                        next_state = sar_pkg::ST_START;
                    end
                end
            end
            sar_pkg::ST_POWER:
            begin
                if (sar_tick)
                begin
                    next_cnt = cnt + 3'h1;
                    if (cnt == `POWERUP_TICKS - 3'h1)
                    begin
                        next_powered = 1'b1;
                        next_cnt     = 3'h0;
                        next_state   = (low_power_track_bit && !ext_mode)
                                       ? sar_pkg::ST_TRACK
                                       : sar_pkg::ST_START;
                    end
                end
            end
            sar_pkg::ST_TRACK:
            begin
                if (sar_tick)
                begin
                    next_cnt = cnt + 3'h1;
                    // RL19 three ticks
                    if (cnt == `LP_TRACK_TICKS - 3'h1)
                    begin
                        next_state = sar_pkg::ST_START;
                    end
                end
            end
            sar_pkg::ST_START:
            begin
                if (sar_tick)
                begin
                    next_start = 1'b1;
                    next_state = sar_pkg::ST_WAIT;
                end
            end
            sar_pkg::ST_WAIT:
            begin
                if (sample_done)
                begin
                    // RL5 accumulate series
                    acc.add  = 1'b1;
                    next_seq = seq + 7'h01;
                    next_cnt = 3'h0;
                    if (seq + 7'h01 == repeat_len)
                    begin
                        // RL12 done on busy fall
                        acc.last     = 1'b1;
                        next_seq     = 7'h00;
                        next_busy    = 1'b0;
                        next_done    = 1'b1;
                        next_powered = 1'b0;
                        next_state   = sar_pkg::ST_IDLE;
                    end
                    // RL17 burst runs the series
                    else if (burst_enable)
                    begin
                        next_state = (low_power_track_bit && !ext_mode)
                                     ? sar_pkg::ST_TRACK
                                     : sar_pkg::ST_START;
                    end
                    else
                    begin
                        next_busy  = 1'b0;
                        next_state = sar_pkg::ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state        <= sar_pkg::ST_IDLE;
            cnt          <= 3'h0;
            seq          <= 7'h00;
            busy         <= 1'b0;
            done         <= 1'b0;
            powered      <= 1'b0;
            ext_prev     <= 1'b0;
            sample_start <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            cnt          <= next_cnt;
            seq          <= next_seq;
            busy         <= next_busy;
            done         <= next_done;
            powered      <= next_powered;
            ext_prev     <= external_convert_start;
            sample_start <= next_start;
        end
    end
endmodule
`default_nettype wire

// ### dv/sar_control_checker.sv
// Port assertions for the ADC control block
`timescale 1ns/1ns
`default_nettype none
module sar_control_checker (
    input  wire logic       clk,                  // system clock
    input  wire logic       rst,                  // sync reset
    input  wire logic [2:0] addr,                 // register address
    input  wire logic [7:0] wdata,                // write data
    input  wire logic       wr,                   // write strobe
    input  wire logic       rd,                   // read strobe
    input  wire logic [7:0] rdata,                // read data
    input  wire logic       tracking,             // track phase
    input  wire logic       converter_power,      // converter powered
    input  wire logic       sample_start,         // conversion start
    input  wire logic       sample_done,          // conversion end
    input  wire logic       conversion_busy_bit,  // busy status
    input  wire logic       conversion_done_flag  // completion flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_done_on_fall;
        $rose(conversion_done_flag) |-> $fell(conversion_busy_bit);
    endproperty
    a_done_on_fall: assert property (p_done_on_fall)
        else $error("done rose without busy falling");
    property p_done_holds;
        conversion_done_flag && !(wr && addr == 3'h0 && !wdata[5])
            |=> conversion_done_flag;
    endproperty
    a_done_holds: assert property (p_done_holds)
        else $error("done dropped without a clear");
    property p_sw_start;
        wr && addr == 3'h0 && wdata[4] && wdata[2:0] == 3'h0
            && !conversion_busy_bit |=> conversion_busy_bit;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start did not set busy");
    property p_busy_fall;
        $fell(conversion_busy_bit) |-> $past(sample_done);
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("busy fell before the conversion ended");
    property p_start_pulse;
        sample_start |=> !sample_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse longer than one cycle");
    property p_start_busy;
        sample_start |-> conversion_busy_bit && converter_power;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start while idle or unpowered");
    property p_track_power;
        tracking |-> converter_power && conversion_busy_bit && !sample_start;
    endproperty
    a_track_power: assert property (p_track_power)
        else $error("tracking outside a powered conversion");
    property p_rdata_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data without a read");
    property p_unmapped;
        rd && addr > 3'h4 |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### dv/sar_analog_model.sv
// Behavioural model of the analog converter behind the control block
`timescale 1ns/1ns
`default_nettype none
module sar_analog_model (
    input  wire logic       clk,          // system clock
    input  wire logic       sample_start, // begin one conversion
    input  wire logic       full,         // answer full-scale codes
    output logic            sample_done,  // conversion finished pulse
    output logic      [9:0] sample_code   // converted code
);
    int wait_cnt = 0;
    initial
    begin
        sample_done = 1'b0;
        sample_code = 10'h000;
    end
    // Latency 1 to 4 cycles; code toggles outside the done pulse
    always @(posedge clk)
    begin
        sample_done <= 1'b0;
        sample_code <= ~sample_code;
        if (sample_start)
            wait_cnt <= 1 + $urandom_range(3);
        else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
        if (wait_cnt == 1)
        begin
            sample_done <= 1'b1;
            sample_code <= full ? 10'h3FF : 10'($urandom);
        end
    end
endmodule
`default_nettype wire

// ### dv/sar_adc_start_accumulate_format_test.sv
// Self-checking bench for the ADC control block
`timescale 1ns/1ns
`default_nettype none
module sar_adc_start_accumulate_format_test;
    logic       clk, rst, wr, rd;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, cfg;
    logic [4:0] tmr;
    logic       t2_split, t3_split, ext, lpo_tick, full, lp;
    logic       power, tracking, sample_start, sample_done, busy, done;
    logic [9:0] sample_code;
    logic [1:0] lpo_cnt = 2'd0;
    int         codes[$];
    int         bad_count = 0;
    int         checked = 0;
    int         lat = 0;

    sar_control i_sar_control (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer0_ovf(tmr[0]), .timer2_low_ovf(tmr[1]),
        .timer2_high_ovf(tmr[2]), .timer2_split(t2_split),
        .timer3_low_ovf(tmr[3]), .timer3_high_ovf(tmr[4]),
        .timer3_split(t3_split), .external_convert_start(ext),
        .lpo_tick(lpo_tick), .converter_power(power), .tracking(tracking),
        .sample_start(sample_start), .sample_done(sample_done),
        .sample_code(sample_code), .conversion_busy_bit(busy),
        .conversion_done_flag(done));
    sar_analog_model i_sar_analog_model (
        .clk(clk), .sample_start(sample_start), .full(full),
        .sample_done(sample_done), .sample_code(sample_code));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        lpo_cnt <= lpo_cnt + 2'd1;
        lpo_tick <= (lpo_cnt == 2'd2);
    end
    always @(posedge clk)
        if (sample_done)
            codes.push_back(int'(sample_code));
    always @(posedge clk)
    begin
        lat <= busy ? lat + 1 : 0;
        if (sample_start && !cfg[5] && !lp)
            check(16'(lat), 16'(cfg[4:0]) + 16'h0002);
    end

    task automatic end_sim;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 8000; i++)
        begin
            @(negedge clk);
            if (busy === lvl)
                break;
        end
        if (i == 8000)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h want=%h", $time, busy, lvl);
            end_sim();
        end
    endtask
    task automatic pulse(input int which);
        @(posedge clk);
        tmr <= 5'(1 << which);
        @(posedge clk);
        tmr <= 5'h00;
    endtask
    function automatic logic [15:0] fmt(input int sum, input logic [2:0] j);
        logic [15:0] s;
        s = sum[15:0];
        if (j == 3'h4)
            return {s[9:0], 6'h00};
        return s >> j[1:0];
    endfunction
    // one start per call, well spaced
    task automatic trigger(input logic [2:0] mode, input logic split);
        int base;
        base = (mode == 3'h2) ? 1 : 3;
        case (mode)
            3'h0: wr_reg(3'h0, {3'b000, 1'b1, lp, mode});
            3'h1: pulse(0);
            3'h2, 3'h3:
            begin
                pulse(base + (split ? 1 : 0));
                @(negedge clk);
                check({15'h0, busy}, 16'h0000);
                pulse(base + (split ? 0 : 1));
            end
            default:
            begin
                @(posedge clk);
                ext <= 1'b0;
                repeat (3) @(posedge clk);
                ext <= 1'b1;
            end
        endcase
    endtask
    task automatic series(input logic [2:0] mode, input logic burst,
        input logic [2:0] rpt, input logic [2:0] jst, input logic lp_v,
        input logic full_v, input logic split);
        int         n;
        int         sum;
        logic [7:0] hi;
        logic [7:0] lo;
        n = (rpt == 3'h0) ? 1 : (rpt >= 3'h5) ? 64 : (2 << rpt);
        lp = lp_v;
        full <= full_v;
        t2_split <= split;
        t3_split <= split;
        wr_reg(3'h2, {2'b00, jst, rpt});
        cfg = {2'b00, burst, 5'($urandom_range(2))};
        wr_reg(3'h1, cfg);
        wr_reg(3'h0, {4'h0, lp, mode});
        codes.delete();
        for (int i = 0; i < (burst ? 1 : n); i++)
        begin
            trigger(mode, split);
            wait_busy(1'b1);
            wait_busy(1'b0);
            check({15'h0, done}, 16'(i == (burst ? 0 : n - 1)));
        end
        check(16'(codes.size()), 16'(n));
        sum = 0;
        foreach (codes[k])
            sum += codes[k];
        rd_reg(3'h3, hi);
        rd_reg(3'h4, lo);
        check({hi, lo}, fmt(sum, jst));
        wr_reg(3'h3, ~hi);
        rd_reg(3'h3, lo);
        check({8'h00, lo}, {8'h00, hi});
        wr_reg(3'h0, {4'h0, lp, mode});
        @(negedge clk);
        check({15'h0, done}, 16'h0000);
    endtask

    initial
    begin
        logic [7:0] v;
        logic [2:0] rm, rr, rj;
        rst = 1'b1;
        {wr, rd, ext, full, lp, t2_split, t3_split} = 7'h00;
        {addr, wdata, tmr} = 16'h0000;
        void'($urandom(32'h2e75c05b));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++)
        begin
            rd_reg(3'(a), v);
            check({8'h00, v}, 16'h0000);
        end
        series(3'h0, 1'b0, 3'h0, 3'h0, 1'b0, 1'b1, 1'b0);
        series(3'h0, 1'b0, 3'h0, 3'h4, 1'b1, 1'b1, 1'b0);
        series(3'h1, 1'b0, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0);
        series(3'h2, 1'b1, 3'h2, 3'h0, 1'b1, 1'b0, 1'b1);
        series(3'h3, 1'b1, 3'h6, 3'h3, 1'b0, 1'b1, 1'b0);
        series(3'h4, 1'b0, 3'h0, 3'h2, 1'b1, 1'b0, 1'b0);
        series(3'h4, 1'b1, 3'h4, 3'h0, 1'b0, 1'b0, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            rm = 3'($urandom_range(4));
            rr = 3'($urandom_range(7));
            rj = 3'($urandom_range(4));
            // right justify with a repeat above one
            if (rr != 3'h0 && rj == 3'h4)
                rj = 3'h0;
            series(rm, 1'($urandom), rr, rj, 1'($urandom), 1'b0,
                1'($urandom));
        end
        end_sim();
    end
endmodule

bind sar_control sar_control_checker i_sar_control_checker (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tracking(tracking), .converter_power(converter_power),
    .sample_start(sample_start), .sample_done(sample_done),
    .conversion_busy_bit(conversion_busy_bit),
    .conversion_done_flag(conversion_done_flag));
`default_nettype wire
